/* File: logic/period_match_timer8.sv */
// five period match timers behind a classic wishbone slave
// Notes on behaviour
// RULE_01: counter climbs from zero; after equalling period, next tick returns zero.
// RULE_02: period register resets to all ones.
// RULE_03: count register is read/write and cleared by reset.
// RULE_04: counter runs from instruction clock (clock/4) through a prescaler.
// RULE_05: prescale code 00 divides by 1, 01 by 4, 1x by 16.
// RULE_06: postscale field plus one gives matches per interrupt.
// RULE_07: completed postscale count sets a flag held until software clears.
// RULE_08: request raised only while enable set; enable never touches flag.
// RULE_09: five flags at bits 0,2,4,5,6; enables at same bits.
// RULE_10: count write, control write or reset clears both scalers.
// RULE_11: control write leaves the count value unchanged.
// RULE_12: run bit 2 enables counting; clear stops the timer.
// RULE_13: control bit 7 reads zero; implemented control bits reset zero.
// RULE_14: unscaled match is only a pwm time base output.
// RULE_15: count, period and control registers are all read/write.
// RULE_16: stopped timer holds counter and scalers; writes still apply.
`timescale 1ns/1ps
`default_nettype none
module period_match_timer8 (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // interrupt
  output logic             irq_o,
  // pwm time base, one pulse per period
  output logic      [4:0]  time_base_o
);
  localparam int unsigned N = timer_pkg::NUM_TMR;

  typedef struct packed {
    logic [1:0]       iclk;
    logic [N-1:0][7:0] ctrl;
    logic [N-1:0][7:0] period;
    logic [7:0]       flag;
    logic [7:0]       enable;
    logic             ack;
    logic [31:0]      rdata;
  } top_st_t;

  localparam top_st_t ST_RST = '{
    iclk:   2'h0,
    ctrl:   {N{timer_pkg::CTRL_RST}},
    period: {N{timer_pkg::PERIOD_RST}},
    flag:   8'h00,
    enable: 8'h00,
    ack:    1'b0,
    rdata:  32'h0000_0000
  };

  top_st_t     st_r;
  top_st_t     st_nxt;
  logic [N-1:0] count_wr;
  logic [N-1:0] ctrl_wr;
  logic [N-1:0] done_w;
  logic [N-1:0] match_w;
  logic [N-1:0][7:0] count_w;
  logic        req;
  logic        commit;
  logic        iclk_tick;
  logic [7:0]  wd;
  logic [7:0]  rd;
  logic [3:0]  sub;

  tmr_link_if link [N] ();

  assign req       = cyc_i & stb_i;
  // write lands at the edge where the master sees ack
  assign commit    = req & st_r.ack & we_i & sel_i[0];
  assign wd        = dat_i[7:0];
  assign sub       = adr_i[3:0];
  // one tick per four system clocks
  assign iclk_tick = (st_r.iclk == timer_pkg::ICLK_LAST); // [RULE_04]

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_tmr
      assign link[g].ctrl      = st_r.ctrl[g];
      assign link[g].period    = st_r.period[g];
      assign link[g].wdata     = wd;
      assign link[g].count_wr  = count_wr[g];
      assign link[g].ctrl_wr   = ctrl_wr[g];
      assign link[g].iclk_tick = iclk_tick;
      assign done_w[g]         = link[g].done;
      assign match_w[g]        = link[g].match;
      assign count_w[g]        = link[g].count;
      period_core u_core (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .lnk   (link[g])
      );
    end
  endgenerate

  always_comb begin
    st_nxt      = st_r;
    count_wr    = '0;
    ctrl_wr     = '0;
    rd          = 8'h00;
    st_nxt.iclk = st_r.iclk + 2'h1;
    // single wait state, dropped after one cycle
    st_nxt.ack  = req & ~st_r.ack;
    // unmapped addresses answer with zero, writes dropped
    if (adr_i == timer_pkg::OFS_FLAG) begin
      rd = st_r.flag;
      if (commit) begin
        st_nxt.flag = st_r.flag & ~(wd & timer_pkg::FLAG_MASK);
      end
    end else if (adr_i == timer_pkg::OFS_ENABLE) begin
      rd = st_r.enable;
      if (commit) begin // [RULE_08] [RULE_09]
        st_nxt.enable = wd & timer_pkg::FLAG_MASK;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (adr_i[7:4] == 4'(i)) begin
          if (sub == timer_pkg::REG_CTRL) begin // [RULE_15]
            rd = st_r.ctrl[i];
            if (commit) begin
              // bit 7 is not stored, so it reads zero
              st_nxt.ctrl[i] = wd & timer_pkg::CTRL_WMASK; // [RULE_13]
              ctrl_wr[i]     = 1'b1; // [RULE_10]
            end
          end else if (sub == timer_pkg::REG_COUNT) begin
            rd = count_w[i]; // [RULE_03]
            if (commit) begin
              count_wr[i] = 1'b1; // [RULE_10]
            end
          end else if (sub == timer_pkg::REG_PERIOD) begin
            rd = st_r.period[i];
            if (commit) begin
              st_nxt.period[i] = wd; // [RULE_15]
            end
          end
        end
      end
    end
    // a flag event beats a clear in the same cycle
    for (int i = 0; i < N; i++) begin
      if (done_w[i]) begin
        st_nxt.flag[timer_pkg::FLAG_POS[i]] = 1'b1; // [RULE_07] [RULE_09]
      end
    end
    st_nxt.rdata = st_nxt.ack ? {24'h00_0000, rd} : 32'h0000_0000;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_RST; // [RULE_02] [RULE_13]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dat_o       = st_r.rdata;
  assign ack_o       = st_r.ack;
  // enable gates the request only, flag stays
  assign irq_o       = |(st_r.flag & st_r.enable); // [RULE_08]
  // pre-postscaler match, for pwm use only, no baud clock
  assign time_base_o = match_w; // [RULE_14]

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence iclk_gap_s;
    !iclk_tick [*3] ##1 iclk_tick;
  endsequence

  sequence bus_req_s;
    req && !st_r.ack;
  endsequence

  reset_values_a: assert property (disable iff (1'b0) // [RULE_02]
    rst_i |=> st_r.period[0] == timer_pkg::PERIOD_RST &&
    st_r.period[N-1] == timer_pkg::PERIOD_RST &&
    st_r.ctrl[0] == timer_pkg::CTRL_RST && st_r.flag == 8'h00)
    else $error("reset values wrong");
  reset_count_a: assert property (disable iff (1'b0) // [RULE_03]
    rst_i |=> count_w[0] == timer_pkg::COUNT_RST &&
    count_w[N-1] == timer_pkg::COUNT_RST)
    else $error("count not cleared by reset");
  iclk_rate_a: assert property (iclk_tick |=> iclk_gap_s) // [RULE_04]
    else $error("instruction tick not every four clocks");
  bus_ack_a: assert property (bus_req_s |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle pulse");
  ctrl_bit7_a: assert property (ack_o && !we_i && // [RULE_13]
    adr_i[7:4] < 4'(N) && sub == timer_pkg::REG_CTRL |-> !dat_o[7])
    else $error("control bit 7 read nonzero");
  period_rw_a: assert property (commit && // [RULE_15]
    adr_i == {4'h0, timer_pkg::REG_PERIOD} |=>
    st_r.period[0] == $past(wd) ##1 ack_o == 1'b0)
    else $error("period write lost");
  flag_set_a: assert property (done_w[2] |=> // [RULE_07] [RULE_09]
    st_r.flag[4])
    else $error("timer flag not set at its bit");
  flag_hold_a: assert property (st_r.flag[0] && !(commit && // [RULE_07]
    adr_i == timer_pkg::OFS_FLAG) |=> st_r.flag[0])
    else $error("flag dropped without software clear");
  enable_gate_a: assert property (commit && // [RULE_08]
    adr_i == timer_pkg::OFS_ENABLE && wd == 8'h00 |=>
    !irq_o && st_r.flag == $past(st_r.flag | {1'b0, done_w[4:2],
    1'b0, done_w[1], 1'b0, done_w[0]}))
    else $error("enable clear touched flag or kept request");
  irq_follow_a: assert property ( // [RULE_08]
    st_r.flag[4] && st_r.enable[4] |-> irq_o)
    else $error("enabled flag raised no request");
  base_pulse_a: assert property (time_base_o[0] |=> // [RULE_14]
    !time_base_o[0])
    else $error("time base pulse longer than one cycle");

  // write of one to a flag bit with no event in the same cycle
  sequence flag_clear_s;
    commit && adr_i == timer_pkg::OFS_FLAG && wd[0] && !done_w[0];
  endsequence

  ack_source_a: assert property (ack_o |-> $past(req))
    else $error("ack without a request");
  rdata_idle_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  rdata_upper_a: assert property (dat_o[31:8] == 24'h00_0000)
    else $error("read data above low byte");
  flag_clear_a: assert property (flag_clear_s |=> // [RULE_07]
    !st_r.flag[0])
    else $error("write of one did not clear flag");
  flag_map1_a: assert property (done_w[1] |=> st_r.flag[2]) // [RULE_09]
    else $error("timer 1 flag not at bit 2");
  flag_map3_a: assert property (done_w[3] |=> st_r.flag[5]) // [RULE_09]
    else $error("timer 3 flag not at bit 5");
  flag_map4_a: assert property (done_w[4] |=> st_r.flag[6]) // [RULE_09]
    else $error("timer 4 flag not at bit 6");
  flag_spare_a: assert property (((st_r.flag | st_r.enable) & // [RULE_09]
    ~timer_pkg::FLAG_MASK) == 8'h00)
    else $error("flag or enable set outside timer bits");
  irq_idle_a: assert property ( // [RULE_08]
    (st_r.flag & st_r.enable) == 8'h00 |-> !irq_o)
    else $error("request without an enabled flag");
  enable_write_a: assert property (commit && // [RULE_08]
    adr_i == timer_pkg::OFS_ENABLE |=>
    st_r.enable == ($past(wd) & timer_pkg::FLAG_MASK))
    else $error("enable write lost");
  ctrl_write_a: assert property (commit && // [RULE_13]
    adr_i == {4'h0, timer_pkg::REG_CTRL} |=>
    st_r.ctrl[0] == ($past(wd) & timer_pkg::CTRL_WMASK))
    else $error("control write lost or stored bit 7");
  count_read_a: assert property (ack_o && !we_i && // [RULE_03]
    adr_i == {4'h0, timer_pkg::REG_COUNT} |->
    dat_o[7:0] == $past(count_w[0]))
    else $error("count read did not return the counter");
endmodule
`default_nettype wire

/* File: logic/timer_pkg.sv */
// constants shared by the period match timer files
package timer_pkg;
  localparam int unsigned NUM_TMR   = 5;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h7F;
  localparam int unsigned PRE_LSB   = 0;
  localparam int unsigned RUN_BIT   = 2;
  localparam int unsigned POST_LSB  = 3;
  localparam logic [1:0] PRE_DIV1   = 2'h0;
  localparam logic [1:0] PRE_DIV4   = 2'h1;
  localparam logic [3:0] PRE_LAST1  = 4'h0;
  localparam logic [3:0] PRE_LAST4  = 4'h3;
  localparam logic [3:0] PRE_LAST16 = 4'hF;
  localparam logic [1:0] ICLK_LAST  = 2'h3;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_COUNT  = 4'h4;
  localparam logic [3:0] REG_PERIOD = 4'h8;
  localparam logic [7:0] OFS_FLAG   = 8'h50;
  localparam logic [7:0] OFS_ENABLE = 8'h54;
  localparam logic [7:0] FLAG_MASK  = 8'h75;
  localparam int unsigned FLAG_POS [NUM_TMR] = '{0, 2, 4, 5, 6};
endpackage

/* File: logic/tmr_link_if.sv */
// link between register file and one timer core
`timescale 1ns/1ps
`default_nettype none
interface tmr_link_if;
  logic [7:0] ctrl;
  logic [7:0] period;
  logic [7:0] wdata;
  logic       count_wr;
  logic       ctrl_wr;
  logic       iclk_tick;
  logic [7:0] count;
  logic       match;
  logic       done;
  modport regs (output ctrl, period, wdata, count_wr, ctrl_wr,
                output iclk_tick, input count, match, done);
  modport core (input ctrl, period, wdata, count_wr, ctrl_wr,
                input iclk_tick, output count, match, done);
endinterface
`default_nettype wire

/* File: logic/period_core.sv */
// one eight-bit timer: prescaler, counter, postscaler
`timescale 1ns/1ps
`default_nettype none
module period_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register file side
  tmr_link_if.core lnk
);
  typedef struct packed {
    logic [3:0] pre;
    logic [3:0] post;
    logic [7:0] count;
    logic       match;
    logic       done;
  } core_st_t;

  localparam core_st_t ST_RST = '{pre: 4'h0, post: 4'h0,
    count: timer_pkg::COUNT_RST, match: 1'b0, done: 1'b0};

  core_st_t   st_r;
  core_st_t   st_nxt;
  logic       run;
  logic       tick;
  logic [3:0] pre_last;
  logic [3:0] post_sel;

  assign run      = lnk.ctrl[timer_pkg::RUN_BIT];
  assign post_sel = lnk.ctrl[timer_pkg::POST_LSB +: 4];

  always_comb begin
    st_nxt       = st_r;
    st_nxt.match = 1'b0;
    st_nxt.done  = 1'b0;
    tick         = 1'b0;
    // 1x codes both give the longest ratio
    if (lnk.ctrl[1:0] == timer_pkg::PRE_DIV1) begin // [RULE_05]
      pre_last = timer_pkg::PRE_LAST1;
    end else if (lnk.ctrl[1:0] == timer_pkg::PRE_DIV4) begin
      pre_last = timer_pkg::PRE_LAST4;
    end else begin
      pre_last = timer_pkg::PRE_LAST16;
    end
    // stopped: everything holds, writes still land
    if (run && lnk.iclk_tick && !lnk.ctrl_wr) begin // [RULE_12] [RULE_16]
      if (st_r.pre >= pre_last) begin // [RULE_04]
        st_nxt.pre = 4'h0;
        tick       = 1'b1;
      end else begin
        st_nxt.pre = st_r.pre + 4'h1;
      end
    end
    if (tick) begin
      if (st_r.count == lnk.period) begin // [RULE_01]
        st_nxt.count = 8'h00;
        st_nxt.match = 1'b1;
        if (st_r.post >= post_sel) begin // [RULE_06]
          st_nxt.post = 4'h0;
          st_nxt.done = 1'b1;
        end else begin
          st_nxt.post = st_r.post + 4'h1;
        end
      end else begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end
    // software write beats a tick in the same cycle
    if (lnk.count_wr) begin // [RULE_03] [RULE_10]
      st_nxt.count = lnk.wdata;
      st_nxt.pre   = 4'h0;
      st_nxt.post  = 4'h0;
      st_nxt.match = 1'b0;
      st_nxt.done  = 1'b0;
    end
    if (lnk.ctrl_wr) begin // [RULE_10] [RULE_11]
      st_nxt.pre  = 4'h0;
      st_nxt.post = 4'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.count = st_r.count;
  assign lnk.match = st_r.match;
  assign lnk.done  = st_r.done;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence wrap_cause_s;
    tick && st_r.count == lnk.period && !lnk.count_wr;
  endsequence

  counter_wrap_a: assert property (wrap_cause_s |=> // [RULE_01]
    st_r.count == 8'h00 && st_r.match)
    else $error("counter did not wrap to zero on match");
  count_load_a: assert property (lnk.count_wr |=> // [RULE_10]
    st_r.count == $past(lnk.wdata) && st_r.pre == 4'h0)
    else $error("count write did not load and clear scalers");
  ctrl_keep_a: assert property (lnk.ctrl_wr && !lnk.count_wr |=> // [RULE_11]
    $stable(st_r.count) && st_r.post == 4'h0)
    else $error("control write disturbed count or kept postscaler");
  stop_hold_a: assert property (!run && !lnk.count_wr |=> // [RULE_12]
    $stable(st_r.count) && !st_r.match)
    else $error("stopped timer changed its count");
  post_done_a: assert property (st_r.done |-> st_r.match && // [RULE_06]
    $past(st_r.post) == $past(post_sel))
    else $error("postscaler finished on wrong match");
endmodule
`default_nettype wire

/* File: verif/pwm_user_model.sv */
// time base user: counts pulses and measures the spacing of timer 0
`timescale 1ns/1ps
`default_nettype none
module pwm_user_model (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // time base from the timers
  input wire logic [4:0] time_base_i
);
  int pulses [5];
  int gap0;
  int last0;
  int cyc;
  // only a period reference, never a baud clock
  always @(posedge clk_i) begin
    cyc++;
    if (rst_i) begin
      pulses = '{default: 0};
      gap0 = 0;
      last0 = 0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (time_base_i[i] === 1'b1) begin
          pulses[i]++;
        end
      end
      if (time_base_i[0] === 1'b1) begin
        gap0 = cyc - last0;
        last0 = cyc;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/period_match_timer8_bench.sv */
// self-checking bench of the five period match timers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
  bad_count++; $display("unexpected %s exp %h got %h", nm, e, s); end end
module period_match_timer8_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        irq_o;
  logic [4:0]  time_base_o;
  int          bad_count = 0;
  int          checks_done = 0;

  period_match_timer8 DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .time_base_o(time_base_o));
  pwm_user_model u (.clk_i(clk_i), .rst_i(rst_i),
    .time_base_i(time_base_o));

  always #50 clk_i = ~clk_i;

  task automatic wb(input logic w, input logic [7:0] a, d,
                    output logic [7:0] q);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'h1;
    adr_i <= a;
    dat_i <= {24'h00_0000, d};
    // only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    sel_i <= 4'h0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    `CHK(nm, e, q)
  endtask

  // bounded wait, the watchdog catches a hang anyway
  task automatic wait_pulses(input int k);
    int p;
    p = u.pulses[0];
    for (int n = 0; n < 2000 && u.pulses[0] < p + k; n++) begin
      @(posedge clk_i);
    end
  endtask

  task automatic test_reset();
    rd_chk("control", 8'h00, 8'h00);
    rd_chk("count", 8'h04, 8'h00);
    rd_chk("period", 8'h08, 8'hFF);
    rd_chk("unmapped", 8'h60, 8'h00);
  endtask

  task automatic test_regs();
    wr(8'h00, 8'hFF);
    rd_chk("control bit7", 8'h00, 8'h7F);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h37);
    rd_chk("stopped count", 8'h04, 8'h37);
    wr(8'h08, 8'h5A);
    rd_chk("period rw", 8'h08, 8'h5A);
    wr(8'h00, 8'h03);
    rd_chk("control rw", 8'h00, 8'h03);
    repeat (40) @(posedge clk_i);
    rd_chk("count kept", 8'h04, 8'h37);
  endtask

  // period 1 wraps every two ticks of the prescaled clock
  task automatic test_prescale();
    int div [4] = '{1, 4, 16, 16};
    wr(8'h08, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, 8'h04 | c[7:0]);
      wait_pulses(3);
      `CHK("wrap spacing", 8 * div[c], u.gap0)
    end
  endtask

  task automatic test_postscale();
    int p;
    wr(8'h00, 8'h00);
    wr(8'h50, 8'h01);
    wr(8'h54, 8'h01);
    rd_chk("enable rw", 8'h54, 8'h01);
    p = u.pulses[0];
    wr(8'h00, 8'h14);
    for (int n = 0; n < 200 && irq_o !== 1'b1; n++) begin
      @(posedge clk_i);
    end
    `CHK("irq raised", 1'b1, irq_o)
    `CHK("matches per flag", 3, u.pulses[0] - p)
    wr(8'h54, 8'h00);
    `CHK("masked irq", 1'b0, irq_o)
    wr(8'h00, 8'h00);
    rd_chk("flag held", 8'h50, 8'h01);
    wr(8'h50, 8'h01);
    rd_chk("flag cleared", 8'h50, 8'h00);
  endtask

  task automatic test_flag_map();
    for (int i = 0; i < 5; i++) begin
      wr(8'h08 + 8'(i * 16), 8'h00);
      // a leftover count above zero would climb all the way round
      wr(8'h04 + 8'(i * 16), 8'h00);
      wr(8'(i * 16), 8'h04);
    end
    repeat (20) @(posedge clk_i);
    for (int i = 0; i < 5; i++) begin
      wr(8'(i * 16), 8'h00);
    end
    rd_chk("flag map", 8'h50, 8'h75);
  endtask

  // reset while running must restore the timer 0, enable and flag reset values
  task automatic test_mid_reset();
    wr(8'h00, 8'h04);
    wr(8'h54, 8'h75);
    wr(8'h08, 8'h10);
    repeat (30) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_reset();
    rd_chk("enable reset", 8'h54, 8'h00);
    rd_chk("flag reset", 8'h50, 8'h00);
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_reset();
    test_regs();
    test_prescale();
    test_postscale();
    test_flag_map();
    test_mid_reset();
    give_verdict();
  end

  // whole run needs close to two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
